// ===== rtl/sfw_serial_port.sv
// Serial port core: transmit queue, transmitter, receiver, flags, pins.
// Assumes control strobes come from logic on CLK_SYS; pins are async.
`timescale 1ns/1ns
`default_nettype none
module sfw_serial_port #(
  parameter int BAUD_DIV = sfw_pkg::BAUD_DIV_DEF
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire sfw_pkg::sfw_stop_t STOP_MODE,
  input wire logic TX_ENABLE,
  input wire logic RX_ENABLE,
  input wire logic NINE_BIT_MODE,
  input wire logic PARITY_ENABLE,
  input wire logic PARITY_ODD,
  input wire logic WAKE_ADDR_MARK,
  input wire logic LOOPBACK_ENABLE,
  input wire logic RECEIVER_SOURCE_SELECT,
  input wire logic SINGLE_WIRE_TX_DIRECTION,
  input wire logic TX_BUFFER_IRQ_ENABLE,
  input wire logic TX_COMPLETE_IRQ_ENABLE,
  input wire logic RX_FULL_IRQ_ENABLE,
  input wire logic IDLE_IRQ_ENABLE,
  input wire logic [3:0] ERROR_IRQ_ENABLE,
  input wire logic DATA_WR,
  input wire logic [7:0] DATA_WR_VALUE,
  input wire logic TX_NINTH_BIT_WR,
  input wire logic TX_NINTH_BIT_VALUE,
  input wire logic STATUS_RD,
  input wire logic DATA_RD,
  input wire logic SLEEP_SET,
  input wire logic RX_PIN,
  input wire logic TX_PIN_I,
  output logic TX_PIN_O,
  output logic TX_PIN_OE,
  output logic RX_PIN_RELEASED,
  output logic TX_BUFFER_EMPTY,
  output logic TX_COMPLETE,
  output logic RX_BUFFER_FULL,
  output logic IDLE_LINE,
  output logic OVERRUN,
  output logic NOISE_DETECTED,
  output logic FRAMING_ERROR,
  output logic PARITY_ERROR,
  output logic RECEIVER_ASLEEP,
  output logic [7:0] RX_DATA,
  output logic RX_NINTH_BIT,
  output logic TX_NINTH_BIT,
  output logic IRQ_TX,
  output logic IRQ_RX,
  output logic IRQ_ERR
);
  import sfw_pkg::*;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  ////////////////////////////////////////////////////////////////////
  // Stop modes and 16x tick
  logic run, wipe, tick;
  logic [15:0] div_q, div_d;
  sfw_tx_t tx_q, tx_d;
  sfw_rx_t rx_q, rx_d;
  sfw_flag_t fl_q, fl_d;
  sfw_out_t out_q, out_d;
  logic rx_s1_q, rx_s2_q, txi_s1_q, txi_s2_q;
  logic q_valid, q_ready, q_pop, q_push;
  logic [DATA_W-1:0] q_data;
  logic loop, single, rx_in, tx_line;
  logic [3:0] flen;
  logic done, idle_evt, noisy, maj, msb, pf_bit, par;
  logic [2:0] smp;
  logic [8:0] word;

  // Clocks stand still in any stop; deep stops also forget everything
  assign run = (STOP_MODE == STOP_RUN); // see [RULE_15]
  assign wipe = (STOP_MODE == STOP_DEEP) || (STOP_MODE == STOP_DEEPEST); // see [RULE_15]
  assign flen = NINE_BIT_MODE ? BITS_9 : BITS_8; // see [RULE_12]

  always_comb begin
    tick = (div_q == 16'(BAUD_DIV - 1));
    div_d = tick ? '0 : div_q + 16'h0001;
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      div_q <= '0;
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      txi_s1_q <= 1'b1;
      txi_s2_q <= 1'b1;
    end else begin
      if (wipe) begin
        div_q <= '0;
      end else if (run) begin
        div_q <= div_d;
      end
      rx_s1_q <= RX_PIN;
      rx_s2_q <= rx_s1_q;
      txi_s1_q <= TX_PIN_I;
      txi_s2_q <= txi_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Transmit queue; the ninth bit is queued with its byte
  assign q_push = DATA_WR && run;

  sfw_fifo #(.WIDTH(DATA_W), .DEPTH(TXQ_DEPTH)) u_txq (
    .clk(CLK_SYS),
    .rst(RESET),
    .clr(wipe),
    .en(run),
    .in_valid(q_push),
    .in_data({(TX_NINTH_BIT_WR ? TX_NINTH_BIT_VALUE : tx_q.ninth), DATA_WR_VALUE}), // see [RULE_14]
    .in_ready(q_ready),
    .out_valid(q_valid),
    .out_data(q_data),
    .out_ready(q_pop)
  );

  ////////////////////////////////////////////////////////////////////
  // Transmitter
  assign tx_line = !tx_q.busy || tx_q.sh[0];

  always_comb begin
    tx_d = tx_q;
    q_pop = 1'b0;
    par = PARITY_ODD ^ (NINE_BIT_MODE ? ^q_data[7:0] : ^q_data[6:0]);
    if (TX_NINTH_BIT_WR) begin
      tx_d.ninth = TX_NINTH_BIT_VALUE; // see [RULE_13]
    end
    if (tick) begin
      if (!tx_q.busy) begin
        if (q_valid && TX_ENABLE) begin
          q_pop = 1'b1;
          tx_d.busy = 1'b1;
          tx_d.ph = '0;
          tx_d.cnt = flen;
          // Parity replaces the top data bit when enabled
          if (NINE_BIT_MODE) begin
            tx_d.sh = {1'b1, (PARITY_ENABLE ? par : q_data[8]), q_data[7:0], 1'b0}; // see [RULE_22]
          end else begin
            tx_d.sh = {2'b11, (PARITY_ENABLE ? par : q_data[7]), q_data[6:0], 1'b0}; // see [RULE_22]
          end
        end
      end else begin
        tx_d.ph = tx_q.ph + 4'h1;
        if (tx_q.ph == PH_LAST) begin
          tx_d.sh = {1'b1, tx_q.sh[10:1]};
          tx_d.cnt = tx_q.cnt - 4'h1;
          tx_d.busy = (tx_q.cnt != 4'h1);
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      tx_q <= '0;
    end else if (wipe) begin
      tx_q <= '0;
    end else if (run) begin
      tx_q <= tx_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Receiver source and frame sampler
  assign loop = LOOPBACK_ENABLE;
  assign single = LOOPBACK_ENABLE && RECEIVER_SOURCE_SELECT; // see [RULE_16]

  always_comb begin
    if (!loop) begin
      rx_in = rx_s2_q;
    end else if (!single || SINGLE_WIRE_TX_DIRECTION) begin
      rx_in = tx_line; // see [RULE_17] see [RULE_20]
    end else begin
      rx_in = txi_s2_q; // see [RULE_18] see [RULE_19]
    end
  end

  always_comb begin
    rx_d = rx_q;
    done = 1'b0;
    idle_evt = 1'b0;
    smp = {rx_q.smp, rx_in};
    maj = (smp[0] & smp[1]) | (smp[0] & smp[2]) | (smp[1] & smp[2]);
    noisy = !(&smp) && (|smp);
    word = NINE_BIT_MODE ? rx_q.sh : {1'b0, rx_q.sh[8:1]};
    msb = rx_q.sh[8];
    pf_bit = PARITY_ENABLE && ((^word) != PARITY_ODD);
    if (tick) begin
      rx_d.prev = rx_in;
      case (rx_q.st)
        RX_HUNT: begin
          if (rx_q.prev && !rx_in && RX_ENABLE) begin
            rx_d.st = RX_FRAME;
            rx_d.ph = '0;
            rx_d.idx = '0;
            rx_d.noise = 1'b0;
            rx_d.ip = '0;
            rx_d.ic = '0;
          end else if (!rx_in) begin
            rx_d.ip = '0;
            rx_d.ic = '0;
          end else begin
            // Counts one character time of marking line, once only
            rx_d.ip = rx_q.ip + 4'h1;
            if (rx_q.ip == PH_LAST && rx_q.ic < flen) begin
              rx_d.ic = rx_q.ic + 4'h1;
              idle_evt = (rx_q.ic == flen - 4'h1);
            end
          end
        end
        RX_FRAME: begin
          rx_d.ph = rx_q.ph + 4'h1;
          if (rx_q.ph >= PH_S1 && rx_q.ph <= PH_S3) begin
            rx_d.smp = smp[1:0];
          end
          if (rx_q.ph == PH_S3) begin
            rx_d.noise = rx_q.noise | noisy;
            if (rx_q.idx == '0 && maj) begin
              rx_d.st = RX_HUNT;
            end else if (rx_q.idx == flen - 4'h1) begin
              done = 1'b1; // see [RULE_22]
              rx_d.st = RX_HUNT;
            end else begin
              if (rx_q.idx != '0) begin
                rx_d.sh = {maj, rx_q.sh[8:1]};
              end
              rx_d.idx = rx_q.idx + 4'h1;
            end
          end
        end
        default: rx_d.st = RX_HUNT;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      rx_q <= '0;
    end else if (wipe) begin
      rx_q <= '0;
    end else if (run) begin
      rx_q <= rx_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Status flags, sleep and read-sequence clearing
  logic active, room, clr_rx_buffer_full, clr_idle, clr_err;

  always_comb begin
    fl_d = fl_q;
    // Waking address character is itself received
    active = !fl_q.asleep || (WAKE_ADDR_MARK && msb); // see [RULE_21]
    clr_rx_buffer_full = DATA_RD && fl_q.seen_rx_buffer_full; // see [RULE_07]
    clr_idle = DATA_RD && fl_q.seen_idle; // see [RULE_08]
    clr_err = DATA_RD && fl_q.seen_err;
    room = !fl_q.rx_buffer_full || clr_rx_buffer_full;
    if (STATUS_RD) begin
      fl_d.seen_rx_buffer_full = fl_q.rx_buffer_full;
      fl_d.seen_idle = fl_q.idle;
      fl_d.seen_err = |fl_q.err;
    end else if (DATA_RD) begin
      fl_d.seen_rx_buffer_full = 1'b0;
      fl_d.seen_idle = 1'b0;
      fl_d.seen_err = 1'b0;
    end
    if (clr_rx_buffer_full) begin
      fl_d.rx_buffer_full = 1'b0;
    end
    if (clr_idle) begin
      fl_d.idle = 1'b0;
    end
    if (clr_err) begin
      fl_d.err = '0;
    end
    // Sets follow the clears so a same-cycle event wins
    if (done && active && room) begin
      fl_d.rx_buffer_full = 1'b1;
      fl_d.data = word; // see [RULE_12]
      fl_d.err[ERR_NF] = fl_q.err[ERR_NF] && !clr_err || rx_q.noise || noisy; // see [RULE_10]
      fl_d.err[ERR_FE] = fl_q.err[ERR_FE] && !clr_err || !maj; // see [RULE_10]
      fl_d.err[ERR_PF] = fl_q.err[ERR_PF] && !clr_err || pf_bit; // see [RULE_10]
      fl_d.armed = 1'b1; // see [RULE_09]
    end else if (done && active) begin
      fl_d.err[ERR_OR] = 1'b1; // see [RULE_11]
    end
    if (idle_evt && fl_q.armed && !fl_q.asleep) begin
      fl_d.idle = 1'b1;
      fl_d.armed = 1'b0; // see [RULE_09]
    end
    if (SLEEP_SET) begin
      fl_d.asleep = 1'b1;
    end
    if (WAKE_ADDR_MARK ? (done && msb) : idle_evt) begin
      fl_d.asleep = 1'b0; // see [RULE_01] see [RULE_21]
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      fl_q <= '0;
    end else if (wipe) begin
      fl_q <= '0;
    end else if (run) begin
      fl_q <= fl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Requests and pins; requests are levels that follow the flags
  always_comb begin
    out_d.tbe = q_ready; // see [RULE_04]
    out_d.tc = !tx_q.busy && !q_valid && tx_line; // see [RULE_05]
    out_d.irq_tx = (out_q.tbe && TX_BUFFER_IRQ_ENABLE) ||
                   (out_q.tc && TX_COMPLETE_IRQ_ENABLE); // see [RULE_02] see [RULE_04] see [RULE_06]
    out_d.irq_rx = (fl_q.rx_buffer_full && RX_FULL_IRQ_ENABLE) ||
                   (fl_q.idle && IDLE_IRQ_ENABLE); // see [RULE_02] see [RULE_03]
    out_d.irq_err = |(fl_q.err & ERROR_IRQ_ENABLE); // see [RULE_02] see [RULE_03]
    out_d.pin_o = tx_line;
    out_d.pin_oe = !(single && !SINGLE_WIRE_TX_DIRECTION); // see [RULE_19]
    out_d.rx_rel = loop; // see [RULE_17] see [RULE_18]
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      out_q <= OUT_RST;
    end else if (wipe) begin
      out_q <= OUT_RST;
    end else if (run) begin
      out_q <= out_d;
    end
  end

  assign TX_PIN_O = out_q.pin_o;
  assign TX_PIN_OE = out_q.pin_oe;
  assign RX_PIN_RELEASED = out_q.rx_rel;
  assign TX_BUFFER_EMPTY = out_q.tbe;
  assign TX_COMPLETE = out_q.tc;
  assign IRQ_TX = out_q.irq_tx;
  assign IRQ_RX = out_q.irq_rx;
  assign IRQ_ERR = out_q.irq_err;
  assign RX_BUFFER_FULL = fl_q.rx_buffer_full;
  assign IDLE_LINE = fl_q.idle;
  assign OVERRUN = fl_q.err[ERR_OR];
  assign NOISE_DETECTED = fl_q.err[ERR_NF];
  assign FRAMING_ERROR = fl_q.err[ERR_FE];
  assign PARITY_ERROR = fl_q.err[ERR_PF];
  assign RECEIVER_ASLEEP = fl_q.asleep;
  assign RX_DATA = fl_q.data[7:0];
  assign RX_NINTH_BIT = fl_q.data[8];
  assign TX_NINTH_BIT = tx_q.ninth;

  ////////////////////////////////////////////////////////////////////
  // Checks
  chk_wake_address_mark: assert property ( // see [RULE_01]
    run && WAKE_ADDR_MARK && fl_q.asleep && done && msb |=> !fl_q.asleep)
    else $error("address mark did not wake receiver");
  chk_tx_irq_level: assert property ( // see [RULE_04]
    run && out_q.tbe && TX_BUFFER_IRQ_ENABLE |=> IRQ_TX)
    else $error("transmit request missing with empty buffer");
  chk_tc_irq_level: assert property ( // see [RULE_06]
    run && out_q.tc && TX_COMPLETE_IRQ_ENABLE |=> IRQ_TX)
    else $error("transmit request missing with complete flag");
  chk_err_mask_off: assert property ( // see [RULE_03]
    run && ERROR_IRQ_ENABLE == 4'h0 |=> !IRQ_ERR)
    else $error("error request raised while all masked");
  chk_tc_when_idle: assert property ( // see [RULE_05]
    run && $past(run) && $rose(out_q.tc) |-> !$past(tx_q.busy) && !$past(q_valid))
    else $error("complete flag set while transmitter busy");
  chk_rx_buffer_full_two_reads: assert property ( // see [RULE_07]
    run && $fell(fl_q.rx_buffer_full) |-> $past(DATA_RD) && $past(fl_q.seen_rx_buffer_full))
    else $error("full flag cleared without status-data reads");
  chk_idle_rearm: assert property ( // see [RULE_09]
    $rose(fl_q.idle) |-> $past(fl_q.armed))
    else $error("idle flag set twice without new character");
  chk_err_with_full: assert property ( // see [RULE_10]
    $rose(fl_q.err[ERR_FE]) |-> $rose(fl_q.rx_buffer_full))
    else $error("framing error set apart from full flag");
  chk_overrun_discard: assert property ( // see [RULE_11]
    run && done && active && fl_q.rx_buffer_full && !DATA_RD |=> OVERRUN && $stable(fl_q.data))
    else $error("overrun character not discarded");
  chk_light_stop_hold: assert property ( // see [RULE_15]
    STOP_MODE == STOP_LIGHT |=> $stable(fl_q) && $stable(tx_q))
    else $error("state changed in light stop");
  chk_single_wire_in: assert property ( // see [RULE_19]
    run && single && !SINGLE_WIRE_TX_DIRECTION |=> !TX_PIN_OE)
    else $error("transmit pin driven while single-wire input");
  chk_asleep_quiet: assert property ( // see [RULE_21]
    fl_q.asleep && !(done && WAKE_ADDR_MARK && msb) |=> !$rose(fl_q.rx_buffer_full))
    else $error("full flag set while receiver asleep");

  cov_overrun: cover property (run && done && fl_q.rx_buffer_full);
  cov_wakeup: cover property (fl_q.asleep ##1 !fl_q.asleep);
  cov_single_rx: cover property (single && !SINGLE_WIRE_TX_DIRECTION && done);
  cov_idle_set: cover property ($rose(fl_q.idle));
endmodule
`default_nettype wire

// ===== rtl/sfw_pkg.sv
// Shared constants and types of the serial port block.
// Assumes one system clock; every slower rate is a tick enable.
// Notes on behaviour
// [RULE_01] Address-mark character MSB one clears sleep
// [RULE_02] Three requests: transmit, receive, errors
// [RULE_03] Eight separate masks; flags always pollable
// [RULE_04] Transmit request while buffer empty and enabled
// [RULE_05] Complete only when idle, queue empty, line high
// [RULE_06] Transmit request while complete flag and enabled
// [RULE_07] Full flag cleared by status then data read
// [RULE_08] Idle flag cleared by same two reads
// [RULE_09] Idle rearms only after a new received character
// [RULE_10] Error flags set together with full flag
// [RULE_11] Character into full buffer: overrun, discarded
// [RULE_12] Nine-bit mode adds ninth bit both ways
// [RULE_13] Stored transmit ninth bit travels, persists
// [RULE_14] Software writes ninth bit before data
// [RULE_15] Stops halt clocks; deep stops lose state
// [RULE_16] Source select picks loop or single-wire
// [RULE_17] Loop mode feeds transmitter into receiver
// [RULE_18] Single-wire receiver listens on transmit pin
// [RULE_19] Direction bit: pin input or driven output
// [RULE_20] Single-wire receiver hears own transmissions
// [RULE_21] Sleep suppresses receive flags until wakeup
// [RULE_22] Frame: low start, data LSB first, high stop
package sfw_pkg;
  localparam int BAUD_DIV_DEF = 16;
  localparam int DATA_W = 9;
  localparam int TXQ_DEPTH = 4;
  localparam logic [3:0] PH_S1 = 4'h7;
  localparam logic [3:0] PH_S3 = 4'h9;
  localparam logic [3:0] PH_LAST = 4'hF;
  localparam logic [3:0] BITS_8 = 4'hA;
  localparam logic [3:0] BITS_9 = 4'hB;
  localparam int ERR_OR = 0;
  localparam int ERR_NF = 1;
  localparam int ERR_FE = 2;
  localparam int ERR_PF = 3;
  localparam logic [7:0] OUT_RST = 8'hC6;

  typedef enum logic [1:0] {
    STOP_RUN = 2'b00,
    STOP_LIGHT = 2'b01,
    STOP_DEEP = 2'b10,
    STOP_DEEPEST = 2'b11
  } sfw_stop_t;

  typedef enum logic {
    RX_HUNT = 1'b0,
    RX_FRAME = 1'b1
  } sfw_rx_st_t;

  typedef struct packed {
    logic busy;
    logic [10:0] sh;
    logic [3:0] cnt;
    logic [3:0] ph;
    logic ninth;
  } sfw_tx_t;

  typedef struct packed {
    sfw_rx_st_t st;
    logic [3:0] ph;
    logic [3:0] idx;
    logic [8:0] sh;
    logic [1:0] smp;
    logic noise;
    logic prev;
    logic [3:0] ip;
    logic [3:0] ic;
  } sfw_rx_t;

  typedef struct packed {
    logic rx_buffer_full;
    logic idle;
    logic [3:0] err;
    logic [8:0] data;
    logic asleep;
    logic armed;
    logic seen_rx_buffer_full;
    logic seen_idle;
    logic seen_err;
  } sfw_flag_t;

  // Order fixes OUT_RST: tbe tc irq_tx irq_rx irq_err pin_o pin_oe rx_rel
  typedef struct packed {
    logic tbe;
    logic tc;
    logic irq_tx;
    logic irq_rx;
    logic irq_err;
    logic pin_o;
    logic pin_oe;
    logic rx_rel;
  } sfw_out_t;
endpackage

// ===== rtl/sfw_fifo.sv
// Small valid/ready FIFO used as the transmit queue.
// Assumes clear and enable come from the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module sfw_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic en,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != FULL);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];

  always_comb begin
    push = en && in_valid && in_ready;
    pop = en && out_valid && out_ready;
    wr_d = push ? ((wr_q == LAST) ? '0 : wr_q + 1'b1) : wr_q;
    rd_d = pop ? ((rd_q == LAST) ? '0 : rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (clr) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  chk_fifo_no_overfill: assert property (@(posedge clk) disable iff (rst)
    cnt_q <= FULL) else $error("transmit queue count above depth");
endmodule
`default_nettype wire

// ===== sim/sfw_remote.sv
// Remote serial device: sends frames onto its line and decodes what it hears.
// Assumes calls arrive 1 ns after a rising edge of the shared clock.
`timescale 1ns/1ns
`default_nettype none
module sfw_remote #(
  parameter int BIT = 16
) (
  input wire logic clk,
  input wire logic nine,
  input wire logic line_i,
  output logic line_o
);
  logic [8:0] got[$];
  logic [8:0] w;
  initial line_o = 1'b1;
  task automatic bit_time();
    repeat (BIT) @(posedge clk);
    #1;
  endtask
  // Trailing idle bit keeps two calls from touching the line in one step
  task automatic send(input logic [8:0] d, input logic stop);
    line_o = 1'b0;
    bit_time();
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      line_o = d[i];
      bit_time();
    end
    line_o = stop;
    bit_time();
    line_o = 1'b1;
    bit_time();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Mid-bit sampling; the word is pushed at the middle of its stop bit, whose level is not checked
  always begin
    @(negedge line_i);
    w = 9'h000;
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < (nine ? 10 : 9); i++) begin
      repeat (BIT) @(posedge clk);
      if (i < (nine ? 9 : 8))
        w[i] = line_i;
    end
    got.push_back(w);
  end
endmodule
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench of the serial port with a remote device on the line.
// Assumes BAUD_DIV of 1, so one bit lasts 16 cycles; strobes 1 ns after edge.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import sfw_pkg::*;
  localparam int BIT = 16;
  logic clk = 1'b0;
  logic rst = 1'b1;
  sfw_stop_t stop = STOP_RUN;
  logic txen = 1'b1, nine = 1'b0, par = 1'b0, wake = 1'b0;
  logic loop = 1'b0, receiver_source_select = 1'b0, dir = 1'b0, tx_buffer_irq_enable = 1'b0, tce = 1'b1, rie = 1'b0;
  logic dwr = 1'b0, t8wr = 1'b0, t8v = 1'b0, srd = 1'b0, drd = 1'b0, slp = 1'b0;
  logic [7:0] wdat = 8'h00;
  logic iie = 1'b0;
  logic [3:0] eie = 4'hF;
  logic tx_o, tx_oe, rx_rel, tbe, tc, rx_buffer_full, idle, ovr, nf, fe, pf, asleep;
  logic rx9, tx9, irq_tx, irq_rx, irq_err, rem_line, wire_lvl, rx_pin;
  logic [7:0] rx_d;
  int err_total = 0;
  int checks = 0;
  assign wire_lvl = tx_oe ? tx_o : rem_line;
  // A released rx pin carries the inverse, so listening to it corrupts data
  assign rx_pin = loop ? ~rem_line : rem_line;
  always #2 clk = ~clk;

  sfw_serial_port #(.BAUD_DIV(1)) i_dut (
    .CLK_SYS(clk), .RESET(rst), .STOP_MODE(stop), .TX_ENABLE(txen), .RX_ENABLE(1'b1),
    .NINE_BIT_MODE(nine), .PARITY_ENABLE(par), .PARITY_ODD(1'b0), .WAKE_ADDR_MARK(wake),
    .LOOPBACK_ENABLE(loop), .RECEIVER_SOURCE_SELECT(receiver_source_select), .SINGLE_WIRE_TX_DIRECTION(dir),
    .TX_BUFFER_IRQ_ENABLE(tx_buffer_irq_enable), .TX_COMPLETE_IRQ_ENABLE(tce), .RX_FULL_IRQ_ENABLE(rie),
    .IDLE_IRQ_ENABLE(iie), .ERROR_IRQ_ENABLE(eie), .DATA_WR(dwr), .DATA_WR_VALUE(wdat),
    .TX_NINTH_BIT_WR(t8wr), .TX_NINTH_BIT_VALUE(t8v), .STATUS_RD(srd), .DATA_RD(drd),
    .SLEEP_SET(slp), .RX_PIN(rx_pin), .TX_PIN_I(wire_lvl), .TX_PIN_O(tx_o),
    .TX_PIN_OE(tx_oe), .RX_PIN_RELEASED(rx_rel), .TX_BUFFER_EMPTY(tbe), .TX_COMPLETE(tc),
    .RX_BUFFER_FULL(rx_buffer_full), .IDLE_LINE(idle), .OVERRUN(ovr), .NOISE_DETECTED(nf),
    .FRAMING_ERROR(fe), .PARITY_ERROR(pf), .RECEIVER_ASLEEP(asleep), .RX_DATA(rx_d),
    .RX_NINTH_BIT(rx9), .TX_NINTH_BIT(tx9), .IRQ_TX(irq_tx), .IRQ_RX(irq_rx),
    .IRQ_ERR(irq_err)
  );
  sfw_remote #(.BIT(BIT)) i_rem (.clk(clk), .nine(nine), .line_i(wire_lvl), .line_o(rem_line));

  ////////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
    step(1);
  endtask
  task automatic wr(input logic [7:0] v);
    wdat = v;
    pulse(dwr);
  endtask
  task automatic clr_rx();
    pulse(srd);
    pulse(drd);
    step(2);
  endtask
  task automatic rx(input logic [8:0] d, input logic stop_lvl);
    i_rem.send(d, stop_lvl);
    step(4);
  endtask
  task automatic wait_tc();
    step(2);
    for (int i = 0; i < 4000 && tc !== 1'b1; i++)
      step(1);
    cmp_flag("tc_done", 1'b1, tc);
    step(2);
  endtask
  task automatic cmp_flag(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic cmp_data(input string n, input logic [8:0] e, input logic [8:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Tests need about 4.3k cycles; the limit of 50k cycles leaves over ten times that
  initial begin
    #200000;
    err_total++;
    complete_run();
  end

  initial begin
    step(16);
    rst = 1'b0;
    step(1);
    cmp_flag("tc", 1'b1, tc);
    cmp_flag("tbe", 1'b1, tbe);
    cmp_flag("pin", 1'b1, tx_o);
    $display("test reset done");
    i_rem.got.delete();
    wr(8'hA5);
    step(2);
    cmp_flag("tc_busy", 1'b0, tc);
    wait_tc();
    cmp_data("tx_byte", 9'h0A5, i_rem.got[0]);
    cmp_flag("irq_tc", 1'b1, irq_tx);
    tce = 1'b0;
    step(2);
    cmp_flag("irq_tc_masked", 1'b0, irq_tx);
    $display("test transmit done");
    txen = 1'b0;
    tx_buffer_irq_enable = 1'b1;
    i_rem.got.delete();
    for (int i = 0; i < 5; i++)
      wr(8'(8'h11 * (i + 1)));
    step(2);
    cmp_flag("tbe_full", 1'b0, tbe);
    cmp_flag("irq_full", 1'b0, irq_tx);
    txen = 1'b1;
    wait_tc();
    cmp_data("tx_count", 9'h004, 9'(i_rem.got.size()));
    for (int i = 0; i < 4; i++)
      cmp_data("tx_fifo", 9'(8'h11 * (i + 1)), i_rem.got[i]);
    cmp_flag("irq_room", 1'b1, irq_tx);
    tx_buffer_irq_enable = 1'b0;
    $display("test queue done");
    rx(9'h03C, 1'b1);
    cmp_flag("rx_buffer_full", 1'b1, rx_buffer_full);
    cmp_flag("nf_clean", 1'b0, nf);
    cmp_data("rx_byte", 9'h03C, {rx9, rx_d});
    cmp_flag("irq_rx_masked", 1'b0, irq_rx);
    rie = 1'b1;
    step(2);
    cmp_flag("irq_rx", 1'b1, irq_rx);
    pulse(drd);
    cmp_flag("rx_buffer_full_kept", 1'b1, rx_buffer_full);
    rx(9'h055, 1'b1);
    cmp_flag("overrun", 1'b1, ovr);
    cmp_data("rx_kept", 9'h03C, {rx9, rx_d});
    cmp_flag("irq_err", 1'b1, irq_err);
    eie = 4'h0;
    step(2);
    cmp_flag("irq_err_masked", 1'b0, irq_err);
    cmp_flag("ovr_polled", 1'b1, ovr);
    eie = 4'hF;
    clr_rx();
    cmp_flag("rx_buffer_full_clr", 1'b0, rx_buffer_full);
    iie = 1'b1;
    step(12 * BIT);
    cmp_flag("idle", 1'b1, idle);
    cmp_flag("irq_idle", 1'b1, irq_rx);
    clr_rx();
    cmp_flag("idle_clr", 1'b0, idle);
    cmp_flag("irq_idle_clr", 1'b0, irq_rx);
    step(30 * BIT);
    cmp_flag("idle_once", 1'b0, idle);
    $display("test receive done");
    rx(9'h042, 1'b0);
    cmp_flag("fe", 1'b1, fe);
    cmp_flag("fe_rx_buffer_full", 1'b1, rx_buffer_full);
    clr_rx();
    par = 1'b1;
    rx(9'h001, 1'b1);
    cmp_flag("pf", 1'b1, pf);
    cmp_flag("pf_rx_buffer_full", 1'b1, rx_buffer_full);
    clr_rx();
    par = 1'b0;
    wake = 1'b1;
    pulse(slp);
    rx(9'h012, 1'b1);
    cmp_flag("asleep", 1'b1, asleep);
    cmp_flag("sleep_rx_buffer_full", 1'b0, rx_buffer_full);
    rx(9'h092, 1'b1);
    cmp_flag("woken", 1'b0, asleep);
    clr_rx();
    wake = 1'b0;
    $display("test errors and wakeup done");
    nine = 1'b1;
    i_rem.got.delete();
    t8v = 1'b1;
    pulse(t8wr); // ninth bit written ahead of the data
    wr(8'h33);
    wr(8'h44);
    wait_tc();
    cmp_flag("t8", 1'b1, tx9);
    cmp_data("tx9_a", 9'h133, i_rem.got[0]);
    cmp_data("tx9_b", 9'h144, i_rem.got[1]);
    rx(9'h1A5, 1'b1);
    cmp_data("rx9", 9'h1A5, {rx9, rx_d});
    clr_rx();
    nine = 1'b0;
    $display("test nine bit done");
    loop = 1'b1;
    step(2);
    cmp_flag("rx_rel", 1'b1, rx_rel);
    wr(8'h5A);
    wait_tc();
    cmp_data("loop_rx", 9'h05A, {rx9, rx_d});
    clr_rx();
    receiver_source_select = 1'b1;
    step(2);
    cmp_flag("oe_in", 1'b0, tx_oe);
    rx(9'h077, 1'b1);
    cmp_data("sw_rx", 9'h077, {rx9, rx_d});
    clr_rx();
    dir = 1'b1;
    step(2);
    cmp_flag("oe_out", 1'b1, tx_oe);
    i_rem.got.delete();
    wr(8'h6B);
    wait_tc();
    cmp_data("sw_echo", 9'h06B, {rx9, rx_d});
    cmp_data("sw_pin", 9'h06B, i_rem.got[0]);
    clr_rx();
    loop = 1'b0;
    receiver_source_select = 1'b0;
    dir = 1'b0;
    $display("test loop done");
    rx(9'h0C3, 1'b1);
    stop = STOP_LIGHT;
    step(4);
    stop = STOP_RUN;
    step(1);
    cmp_flag("light_keep", 1'b1, rx_buffer_full);
    for (int k = 0; k < 2; k++) begin
      rx(9'h0C3, 1'b1);
      stop = k ? STOP_DEEPEST : STOP_DEEP;
      step(2);
      stop = STOP_RUN;
      step(1);
      cmp_flag("deep_lost", 1'b0, rx_buffer_full);
    end
    $display("test stop done");
    complete_run();
  end
endmodule
`default_nettype wire
